// file: pkg/epc_defines.vh
// Object indices, field positions, reset values and codes of the communication-object bank
`ifndef EPC_DEFINES_VH
`define EPC_DEFINES_VH

// Object indices
`define EPC_IDX_DEVTYPE       16'h1000
`define EPC_IDX_ERRREG        16'h1001
`define EPC_IDX_SYNC_ID       16'h1005
`define EPC_IDX_CYCLE         16'h1006
`define EPC_IDX_EMCY_ID       16'h1014
`define EPC_IDX_HB_CONS       16'h1016
`define EPC_IDX_HB_PROD       16'h1017
`define EPC_IDX_IDENTITY      16'h1018
`define EPC_IDX_ERR_REACT     16'h1029
`define EPC_IDX_VDEVTYPE      16'h67FF

// Sub-indices
`define EPC_SUB_COUNT         8'h00
`define EPC_SUB_COMM          8'h01
`define EPC_SUB_INTERNAL      8'h02
`define EPC_SUB_REVISION      8'h03

// Error reaction array
`define EPC_ERR_CLASS_COUNT   8'h02
`define EPC_REACT_RESET       8'h00
`define EPC_REACT_PREOP       8'h00
`define EPC_REACT_KEEP        8'h01
`define EPC_REACT_STOP        8'h02
`define EPC_REACT_MAX         8'h02

// Revision number layout
`define EPC_REV_MAJHI_MSB     31
`define EPC_REV_MAJHI_LSB     24
`define EPC_REV_MAJLO_MSB     23
`define EPC_REV_MAJLO_LSB     16
`define EPC_REV_MINOR_MSB     15
`define EPC_REV_MINOR_LSB     0

// Device type layout and specific-function codes
`define EPC_DT_FUNC_LSB       24
`define EPC_DT_CLASS_LSB      16
`define EPC_DT_PROFILE        16'h01A4
`define EPC_DT_MULTI          16'h0FFF
`define EPC_CLASS_MASTER      8'h00
`define EPC_CLASS_COEXT       8'h04
`define EPC_FUNC_SIMPLE       8'h01
`define EPC_FUNC_ADVANCED     8'h02
`define EPC_FUNC_NONE         8'h00

// Error register: profile-specific bit
`define EPC_ERRREG_PROF_BIT   5

// Heartbeat producer default bounds, ms
`define EPC_HB_MIN            16'h0064
`define EPC_HB_MAX            16'h03E8

// Access answers
`define EPC_ACC_OK            2'h0
`define EPC_ACC_NOOBJ         2'h1
`define EPC_ACC_READONLY      2'h2
`define EPC_ACC_RANGE         2'h3

// Network-management states
`define EPC_NMT_PREOP         2'h0
`define EPC_NMT_OPER          2'h1
`define EPC_NMT_STOP          2'h2

`endif

// file: rtl/epc_reaction.v
// Fault reaction unit: turns a fault event and a reaction code into a state request
`timescale 1ns/1ps
`include "epc_defines.vh"

module epc_reaction (
    // Clock and reset
    input  wire       clock,
    input  wire       rst,
    // Fault inputs
    input  wire       faultHit,
    input  wire [7:0] reactCode,
    input  wire [1:0] nmtState,
    // State request
    output reg        stateReq_r,
    output reg  [1:0] stateNew_r
);

//--------------------------------------------------------------
// Reaction decode
//--------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        stateReq_r <= 1'b0;
        stateNew_r <= `EPC_NMT_PREOP;
    end else begin
        stateReq_r <= 1'b0;
        stateNew_r <= nmtState;
        if (faultHit) begin
            if (reactCode == `EPC_REACT_PREOP) begin
                if (nmtState == `EPC_NMT_OPER) begin
                    stateReq_r <= 1'b1;
                    stateNew_r <= `EPC_NMT_PREOP;
                end
            end else if (reactCode == `EPC_REACT_STOP) begin
                stateReq_r <= 1'b1;
                stateNew_r <= `EPC_NMT_STOP;
            end
        end
    end
end

endmodule

// file: rtl/epc_comm_objects.v
// Communication-object bank of an extruder-line device
`timescale 1ns/1ps
`include "epc_defines.vh"

module epc_comm_objects #(
    parameter [7:0]  DEV_CLASS  = 8'h04,
    parameter [7:0]  DEV_FUNC   = 8'h01,
    parameter        HAS_REACT  = 1,
    parameter        MULTI_DEV  = 0,
    parameter [7:0]  VDEV_CLASS = 8'h01,
    // Arbitrary identity-neutral values
    parameter [7:0]  REV_MAJHI  = 8'h03,
    parameter [7:0]  REV_MAJLO  = 8'h01,
    parameter [15:0] REV_MINOR  = 16'h0001,
    parameter [15:0] HB_DEFAULT = 16'h01F4,
    parameter [10:0] SYNC_ID    = 11'h080,
    parameter [10:0] EMCY_ID    = 11'h081
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst,
    // Object dictionary access
    input  wire        odReq,
    input  wire        odWrite,
    input  wire [15:0] odIndex,
    input  wire [7:0]  odSub,
    input  wire [31:0] odWdata,
    output reg         odAck_r,
    output reg  [31:0] odRdata_r,
    output reg  [1:0]  odErr_r,
    // Fault events
    input  wire        busOff,
    input  wire        lifeGuardEvt,
    input  wire        heartbeatEvt,
    input  wire        internalFault,
    input  wire [7:0]  errRegIn,
    // Network-management state and error register
    input  wire        nmtCmd,
    input  wire [1:0]  nmtCmdState,
    output reg  [1:0]  nmtState_r,
    output reg  [7:0]  errReg_r
);

//--------------------------------------------------------------
// Constants and storage
//--------------------------------------------------------------
localparam IS_MASTER = (DEV_CLASS == `EPC_CLASS_MASTER);

localparam [7:0] FUNC_CODE =
    (DEV_CLASS == `EPC_CLASS_COEXT) ?
        (((DEV_FUNC == `EPC_FUNC_SIMPLE) || (DEV_FUNC == `EPC_FUNC_ADVANCED)) ?
            DEV_FUNC : `EPC_FUNC_SIMPLE) :
    // no function for other downstream devices
    ((DEV_CLASS == `EPC_CLASS_MASTER) ? DEV_FUNC : `EPC_FUNC_NONE);

localparam [7:0] MAJHI = ((REV_MAJHI >= 8'h01) && (REV_MAJHI <= 8'h04)) ? REV_MAJHI : 8'h01;
localparam [15:0] HB_INIT = (HB_DEFAULT < `EPC_HB_MIN) ? `EPC_HB_MIN :
                            (HB_DEFAULT > `EPC_HB_MAX) ? `EPC_HB_MAX : HB_DEFAULT;

reg  [7:0]  commReact_r;
reg  [7:0]  intReact_r;
reg  [15:0] hbPeriod_r;
reg  [31:0] cyclePeriod_r;
reg  [31:0] hbConsumer_r;
reg  [31:0] syncCfg_r;
reg  [31:0] emcyCfg_r;
reg  [31:0] rdNxt;
reg  [1:0]  errNxt;
wire [1:0]  nmtReq;
wire        nmtReqVal;
wire        commFault;
wire        faultHit;
wire [7:0]  reactSel;
wire [7:0]  errMask;
wire        wrOk;
wire        wrSync;
wire        wrEmcy;
wire        wrCycle;
wire        wrHbCons;
wire        wrHbProd;
wire        wrComm;
wire        wrInt;
genvar      gi;

wire [31:0] revision = {MAJHI, REV_MAJLO, REV_MINOR};
wire [31:0] devType  = {FUNC_CODE, DEV_CLASS,
                        MULTI_DEV ? `EPC_DT_MULTI : `EPC_DT_PROFILE};
wire [31:0] vdevType = {`EPC_FUNC_NONE, VDEV_CLASS, `EPC_DT_PROFILE};

function objKnown;
    input [15:0] idx;
    begin
        objKnown = (idx == `EPC_IDX_DEVTYPE) || (idx == `EPC_IDX_ERRREG) ||
                   (idx == `EPC_IDX_SYNC_ID) || (idx == `EPC_IDX_EMCY_ID) ||
                   (idx == `EPC_IDX_HB_PROD) || (idx == `EPC_IDX_IDENTITY) ||
                   (IS_MASTER && ((idx == `EPC_IDX_CYCLE) || (idx == `EPC_IDX_HB_CONS))) ||
                   (HAS_REACT && (idx == `EPC_IDX_ERR_REACT)) ||
                   (MULTI_DEV && (idx == `EPC_IDX_VDEVTYPE));
    end
endfunction

function rangeOk;
    input [31:0] val;
    begin
        rangeOk = (val <= {24'h000000, `EPC_REACT_MAX});
    end
endfunction

// Entry of the error-reaction array
function reactSub;
    input [15:0] idx;
    input [7:0]  sub;
    input [7:0]  want;
    begin
        reactSub = (idx == `EPC_IDX_ERR_REACT) && (sub == want);
    end
endfunction

// Commands carrying an undefined state code are dropped
function stateLegal;
    input [1:0] st;
    begin
        stateLegal = (st == `EPC_NMT_PREOP) || (st == `EPC_NMT_OPER) ||
                     (st == `EPC_NMT_STOP);
    end
endfunction

//--------------------------------------------------------------
// Read decode
//--------------------------------------------------------------
always @* begin
    rdNxt  = 32'h00000000;
    errNxt = `EPC_ACC_OK;
    if (!objKnown(odIndex)) begin
        errNxt = `EPC_ACC_NOOBJ;
    end else if (odIndex == `EPC_IDX_DEVTYPE) begin
        rdNxt = devType;
    end else if (odIndex == `EPC_IDX_ERRREG) begin
        rdNxt = {24'h000000, errReg_r};
    end else if (odIndex == `EPC_IDX_SYNC_ID) begin
        rdNxt = syncCfg_r;
    end else if (odIndex == `EPC_IDX_EMCY_ID) begin
        rdNxt = emcyCfg_r;
    end else if (odIndex == `EPC_IDX_CYCLE) begin
        rdNxt = cyclePeriod_r;
    end else if (odIndex == `EPC_IDX_HB_CONS) begin
        rdNxt = hbConsumer_r;
    end else if (odIndex == `EPC_IDX_HB_PROD) begin
        rdNxt = {16'h0000, hbPeriod_r};
    end else if (odIndex == `EPC_IDX_IDENTITY) begin
        if (odSub == `EPC_SUB_REVISION) rdNxt = revision;
        else errNxt = `EPC_ACC_NOOBJ;
    end else if (odIndex == `EPC_IDX_ERR_REACT) begin
        if (odSub == `EPC_SUB_COUNT) rdNxt = {24'h000000, `EPC_ERR_CLASS_COUNT};
        else if (odSub == `EPC_SUB_COMM) rdNxt = {24'h000000, commReact_r};
        else if (odSub == `EPC_SUB_INTERNAL) rdNxt = {24'h000000, intReact_r};
        else errNxt = `EPC_ACC_NOOBJ;
    end else begin
        rdNxt = vdevType;
    end
    if (odWrite && (errNxt == `EPC_ACC_OK)) begin
        rdNxt = 32'h00000000;
        if ((odIndex == `EPC_IDX_DEVTYPE) || (odIndex == `EPC_IDX_ERRREG) ||
            (odIndex == `EPC_IDX_IDENTITY) || (odIndex == `EPC_IDX_VDEVTYPE)) begin
            errNxt = `EPC_ACC_READONLY;
        end else if (odIndex == `EPC_IDX_ERR_REACT) begin
            if (odSub == `EPC_SUB_COUNT) errNxt = `EPC_ACC_READONLY;
            else if (!rangeOk(odWdata)) errNxt = `EPC_ACC_RANGE;
        end
    end
end

//--------------------------------------------------------------
// Write strobes
//--------------------------------------------------------------
// Accepted write of any object
assign wrOk     = odReq && odWrite && (errNxt == `EPC_ACC_OK);
assign wrSync   = wrOk && (odIndex == `EPC_IDX_SYNC_ID);
assign wrEmcy   = wrOk && (odIndex == `EPC_IDX_EMCY_ID);
assign wrCycle  = wrOk && (odIndex == `EPC_IDX_CYCLE);
assign wrHbCons = wrOk && (odIndex == `EPC_IDX_HB_CONS);
assign wrHbProd = wrOk && (odIndex == `EPC_IDX_HB_PROD);
assign wrComm   = wrOk && reactSub(odIndex, odSub, `EPC_SUB_COMM);
assign wrInt    = wrOk && reactSub(odIndex, odSub, `EPC_SUB_INTERNAL);

//--------------------------------------------------------------
// Access answer and writable objects
//--------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        odAck_r       <= 1'b0;
        odRdata_r     <= 32'h00000000;
        odErr_r       <= `EPC_ACC_OK;
        commReact_r   <= `EPC_REACT_RESET;
        intReact_r    <= `EPC_REACT_RESET;
        hbPeriod_r    <= HB_INIT;
        cyclePeriod_r <= 32'h00000000;
        hbConsumer_r  <= 32'h00000000;
        syncCfg_r     <= {21'h000000, SYNC_ID};
        emcyCfg_r     <= {21'h000000, EMCY_ID};
    end else begin
        odAck_r <= odReq;
        if (odReq) begin
            odRdata_r <= rdNxt;
            odErr_r   <= errNxt;
        end
        if (wrSync)
            syncCfg_r <= {odWdata[31:11], syncCfg_r[10:0]};
        if (wrEmcy)
            emcyCfg_r <= {odWdata[31:11], emcyCfg_r[10:0]};
        if (wrCycle)
            cyclePeriod_r <= odWdata;
        if (wrHbCons)
            hbConsumer_r <= odWdata;
        if (wrHbProd)
            hbPeriod_r <= odWdata[15:0];
        if (wrComm)
            commReact_r <= odWdata[7:0];
        if (wrInt)
            intReact_r <= odWdata[7:0];
    end
end

//--------------------------------------------------------------
// Error register
//--------------------------------------------------------------
// profile-specific bit masked off
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gErrMask
        assign errMask[gi] = (gi != `EPC_ERRREG_PROF_BIT);
    end
endgenerate

always @(posedge clock) begin
    if (rst) begin
        errReg_r <= 8'h00;
    end else begin
        errReg_r <= errRegIn & errMask;
    end
end

//--------------------------------------------------------------
// Fault reaction
//--------------------------------------------------------------
// communication fault sources
assign commFault = busOff | lifeGuardEvt | heartbeatEvt;
assign faultHit  = commFault | internalFault;
assign reactSel  = !HAS_REACT ? `EPC_REACT_PREOP :
                   commFault  ? commReact_r : intReact_r;

epc_reaction uReact (
    .clock      (clock),
    .rst        (rst),
    .faultHit   (faultHit),
    .reactCode  (reactSel),
    .nmtState   (nmtState_r),
    .stateReq_r (nmtReqVal),
    .stateNew_r (nmtReq)
);

//--------------------------------------------------------------
// Network-management state
//--------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        nmtState_r <= `EPC_NMT_PREOP;
    end else if (nmtReqVal) begin
        nmtState_r <= nmtReq;
    end else if (nmtCmd && stateLegal(nmtCmdState)) begin
        nmtState_r <= nmtCmdState;
    end
end

endmodule

// file: sim/epc_comm_objects_asserts.sv
// Port checks of the communication-object bank
`timescale 1ns/1ps
module epc_comm_objects_chk #(
    parameter [7:0]  REV_MAJHI = 8'h03,
    parameter [7:0]  REV_MAJLO = 8'h01,
    parameter [15:0] REV_MINOR = 16'h0001,
    parameter [10:0] SYNC_ID   = 11'h080,
    parameter [10:0] EMCY_ID   = 11'h081
) (
    // Clock and reset
    input wire        clock,
    input wire        rst,
    // Object access
    input wire        odReq,
    input wire        odWrite,
    input wire [15:0] odIndex,
    input wire [7:0]  odSub,
    input wire [31:0] odWdata,
    input wire [31:0] odRdata_r,
    input wire [1:0]  odErr_r,
    // Faults and state
    input wire        busOff,
    input wire        lifeGuardEvt,
    input wire        heartbeatEvt,
    input wire [7:0]  errRegIn,
    input wire        nmtCmd,
    input wire [1:0]  nmtState_r,
    input wire [7:0]  errReg_r
);
    reg  [7:0] commReact;
    wire       commHit = busOff | lifeGuardEvt | heartbeatEvt;
    // Shadow of the accepted communication reaction
    always @(posedge clock) begin
        if (rst) begin
            commReact <= 8'h00;
        end else if (odReq && odWrite && odIndex == 16'h1029 && odSub == 8'h01
                     && odWdata <= 32'h00000002) begin
            commReact <= odWdata[7:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_acc(logic w, logic [15:0] i, logic [7:0] s);
        odReq && odWrite == w && odIndex == i && odSub == s;
    endsequence
    sequence s_fault(logic [7:0] c);
        commHit && commReact == c && !nmtCmd;
    endsequence
    property p_err_reg;
        !$past(rst) |-> errReg_r == ($past(errRegIn) & 8'hDF);
    endproperty
    property p_count_const;
        s_acc(1'b1, 16'h1029, 8'h00) |=> odErr_r == 2'h2;
    endproperty
    property p_count_read;
        s_acc(1'b0, 16'h1029, 8'h00) |=> odErr_r == 2'h0 && odRdata_r == 32'h00000002;
    endproperty
    property p_range;
        s_acc(1'b1, 16'h1029, 8'h01) ##0 odWdata > 32'h00000002 |=> odErr_r == 2'h3;
    endproperty
    property p_sync_fixed;
        s_acc(1'b0, 16'h1005, 8'h00) |=> odRdata_r[10:0] == SYNC_ID;
    endproperty
    property p_emcy_fixed;
        s_acc(1'b0, 16'h1014, 8'h00) |=> odRdata_r[10:0] == EMCY_ID;
    endproperty
    property p_rev;
        s_acc(1'b0, 16'h1018, 8'h03) |=> odRdata_r == {REV_MAJHI, REV_MAJLO, REV_MINOR};
    endproperty
    property p_rev_ver;
        s_acc(1'b0, 16'h1018, 8'h03) |=> odRdata_r[31:24] inside {[8'h01:8'h04]};
    endproperty
    property p_stop;
        s_fault(8'h02) |-> ##2 nmtState_r == 2'h2;
    endproperty
    property p_keep;
        s_fault(8'h01) |-> ##1 $stable(nmtState_r) ##1 $stable(nmtState_r);
    endproperty
    property p_preop;
        s_fault(8'h00) ##0 nmtState_r == 2'h1 |-> ##2 nmtState_r == 2'h0;
    endproperty
    a_err_reg: assert property (p_err_reg) else $error("profile bit seen");
    a_count_const: assert property (p_count_const) else $error("count written");
    a_count_read: assert property (p_count_read) else $error("count value");
    a_range: assert property (p_range) else $error("range accepted");
    a_sync_fixed: assert property (p_sync_fixed) else $error("sync id moved");
    a_emcy_fixed: assert property (p_emcy_fixed) else $error("emcy id moved");
    a_rev: assert property (p_rev) else $error("revision layout");
    a_rev_ver: assert property (p_rev_ver) else $error("revision version");
    a_stop: assert property (p_stop) else $error("stop reaction");
    a_keep: assert property (p_keep) else $error("keep reaction");
    a_preop: assert property (p_preop) else $error("preop reaction");
endmodule
bind epc_comm_objects epc_comm_objects_chk #(
    .REV_MAJHI(REV_MAJHI), .REV_MAJLO(REV_MAJLO), .REV_MINOR(REV_MINOR),
    .SYNC_ID(SYNC_ID), .EMCY_ID(EMCY_ID)
) u_chk (
    .clock(clock), .rst(rst), .odReq(odReq), .odWrite(odWrite), .odIndex(odIndex),
    .odSub(odSub), .odWdata(odWdata), .odRdata_r(odRdata_r), .odErr_r(odErr_r),
    .busOff(busOff), .lifeGuardEvt(lifeGuardEvt), .heartbeatEvt(heartbeatEvt),
    .errRegIn(errRegIn), .nmtCmd(nmtCmd), .nmtState_r(nmtState_r), .errReg_r(errReg_r)
);

// file: sim/epc_master_model.sv
// Line master model: object accesses, state commands and fault events
`timescale 1ns/1ps
module epc_master_model (
    // Clock
    input  wire        clock,
    // Object access
    output reg         odReq,
    output reg         odWrite,
    output reg  [15:0] odIndex,
    output reg  [7:0]  odSub,
    output reg  [31:0] odWdata,
    input  wire        odAck_r,
    input  wire [31:0] odRdata_r,
    input  wire [1:0]  odErr_r,
    // Faults, command and raw error register
    output reg  [3:0]  faults,
    output reg  [7:0]  errRegIn,
    output reg         nmtCmd,
    output reg  [1:0]  nmtCmdState
);
    initial begin
        {odReq, odWrite, odIndex, odSub, odWdata, faults, errRegIn} = 0;
        {nmtCmd, nmtCmdState} = 0;
    end
    // master writes only in range, except refusal tests
    task access(input w, input [15:0] i, input [7:0] s, input [31:0] d,
                output [31:0] rd, output [1:0] er, output ak);
        begin
            @(posedge clock);
            odReq <= 1'b1;
            {odWrite, odIndex, odSub, odWdata} <= {w, i, s, d};
            @(posedge clock);
            odReq <= 1'b0;
            // Answer taken at the edge where the acknowledge stands
            @(posedge clock);
            {rd, er, ak} = {odRdata_r, odErr_r, odAck_r};
            // Released lines show the inverse, not the last value
            {odWrite, odIndex, odSub, odWdata} <= ~{w, i, s, d};
        end
    endtask
    task pulse(input [3:0] m);
        begin
            @(posedge clock);
            faults <= m;
            @(posedge clock);
            faults <= 4'h0;
            repeat (2) @(posedge clock);
            #1;
        end
    endtask
    task set_err(input [7:0] v);
        begin
            @(posedge clock);
            errRegIn <= v;
        end
    endtask
    task command(input [1:0] st);
        begin
            @(posedge clock);
            {nmtCmd, nmtCmdState} <= {1'b1, st};
            @(posedge clock);
            {nmtCmd, nmtCmdState} <= {1'b0, ~st};
            repeat (2) @(posedge clock);
        end
    endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench of the communication-object bank
`timescale 1ns/1ps
module testbench;
    reg         clock;
    reg         rst;
    wire        odReq, odWrite, odAck_r, nmtCmd;
    wire [15:0] odIndex;
    wire [7:0]  odSub, errRegIn, errReg_r;
    wire [31:0] odWdata, odRdata_r;
    wire [1:0]  odErr_r, nmtCmdState, nmtState_r;
    wire [3:0]  faults;
    reg  [31:0] rdat;
    reg  [1:0]  rerr;
    reg         ack;
    integer     failures, check_count, cycles, c, k;
    epc_comm_objects dut (
        .clock(clock), .rst(rst), .odReq(odReq), .odWrite(odWrite), .odIndex(odIndex),
        .odSub(odSub), .odWdata(odWdata), .odAck_r(odAck_r), .odRdata_r(odRdata_r),
        .odErr_r(odErr_r), .busOff(faults[3]), .lifeGuardEvt(faults[2]),
        .heartbeatEvt(faults[1]), .internalFault(faults[0]), .errRegIn(errRegIn),
        .nmtCmd(nmtCmd), .nmtCmdState(nmtCmdState), .nmtState_r(nmtState_r),
        .errReg_r(errReg_r));
    epc_master_model pm (
        .clock(clock), .odReq(odReq), .odWrite(odWrite), .odIndex(odIndex),
        .odSub(odSub), .odWdata(odWdata), .odAck_r(odAck_r), .odRdata_r(odRdata_r),
        .odErr_r(odErr_r), .faults(faults), .errRegIn(errRegIn), .nmtCmd(nmtCmd),
        .nmtCmdState(nmtCmdState));
    always #10 clock = ~clock;
    task complete_run;
        begin
            if (failures == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            complete_run;
        end
    end
    task check(input [33:0] seen, input [33:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task acc(input w, input [15:0] i, input [7:0] s, input [31:0] d);
        begin
            pm.access(w, i, s, d, rdat, rerr, ack);
            check({31'h0, ack}, 32'h1);
        end
    endtask
    initial begin
        {clock, rst, failures, check_count, cycles} = {2'b01, 96'h0};
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        acc(1'b0, 16'h1029, 8'h00, 32'h0);
        check({rerr, rdat}, 34'h2);
        acc(1'b1, 16'h1029, 8'h00, 32'h5);
        check(rerr, 2'h2);
        acc(1'b0, 16'h1029, 8'h02, 32'h0);
        check({rerr, rdat}, 34'h0);
        acc(1'b1, 16'h1029, 8'h01, 32'h1);
        acc(1'b1, 16'h1029, 8'h01, 32'h3);
        check(rerr, 2'h3);
        acc(1'b0, 16'h1029, 8'h01, 32'h0);
        check(rdat, 32'h1);
        acc(1'b0, 16'h1018, 8'h03, 32'h0);
        check(rdat, 32'h03010001);
        acc(1'b0, 16'h1017, 8'h00, 32'h0);
        check(rdat, 32'h000001F4);
        acc(1'b0, 16'h1000, 8'h00, 32'h0);
        check(rdat, 32'h010401A4);
        for (k = 0; k < 2; k = k + 1) begin
            acc(1'b1, k ? 16'h1014 : 16'h1005, 8'h00, 32'h0);
            acc(1'b0, k ? 16'h1014 : 16'h1005, 8'h00, 32'h0);
            check(rdat[10:0], k ? 11'h081 : 11'h080);
        end
        for (k = 0; k < 4; k = k + 1) begin
            acc(1'b0, k[1] ? (k[0] ? 16'h2000 : 16'h67FF) : (k[0] ? 16'h1016 : 16'h1006),
                8'h00, 32'h0);
            check(rerr, 2'h1);
        end
        pm.set_err(8'hFF);
        repeat (2) @(posedge clock);
        #1 check(errReg_r, 8'hDF);
        for (c = 0; c < 3; c = c + 1)
            for (k = 0; k < 4; k = k + 1) begin
                pm.command(2'h1);
                acc(1'b1, 16'h1029, k == 0 ? 8'h02 : 8'h01, c);
                acc(1'b1, 16'h1029, k == 0 ? 8'h01 : 8'h02, 32'h1);
                pm.pulse(4'h1 << k);
                check(nmtState_r, c == 0 ? 2'h0 : (c == 1 ? 2'h1 : 2'h2));
            end
        pm.command(2'h2);
        acc(1'b1, 16'h1029, 8'h01, 32'h0);
        pm.pulse(4'h8);
        check(nmtState_r, 2'h2);
        @(posedge clock) rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        acc(1'b0, 16'h1029, 8'h02, 32'h0);
        check(rdat, 32'h0);
        complete_run;
    end
endmodule
